// [shared/tx_regs_pkg.sv]
// constants for the transmit control register bank
package tx_regs_pkg;
   localparam int ADDR_W = 6;
   // register address: bit 5 is the high select bit, bits 4-0 the register
   localparam logic [4:0] TX_DATA_ADDR = 5'h10;      // 1x000 with bit 3 ignored
   localparam logic [4:0] TX_DATA_MASK = 5'h17;
   localparam logic [4:0] TX_MODE_ADDR = 5'h19;      // 11001
   localparam logic [4:0] TX_CMD_STAT_ADDR = 5'h1a;  // 11010
   localparam logic [4:0] TX_INT_CTRL_ADDR = 5'h1b;  // chosen word for control
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_AW = 5;
   localparam logic [15:0] TX_MODE_RESET = 16'h0000;
   localparam logic [7:0] TX_ICTRL_LO_RESET = 8'h00;
   localparam logic [7:0] THRESH_RESET = 8'h00;
   // command field of the command/status word
   localparam int CMD_LSB = 12;
   localparam logic [3:0] CMD_VIEW_VACANCY = 4'h5;
   localparam logic [3:0] CMD_VIEW_INT = 4'h6;
   localparam logic [3:0] CMD_VIEW_DMA = 4'h7;
   localparam logic [3:0] CMD_SEND_FRAME = 4'h8;
   // bit positions in the interrupt control low byte and status word
   localparam int BIT_PREAMBLE = 7;
   localparam int BIT_IDLE = 6;
   localparam int BIT_ABORT = 5;
   localparam int BIT_FRAME_END = 4;
   localparam int BIT_CRC = 3;
   localparam int BIT_HOLD = 2;
   localparam int BIT_UNDERFLOW = 1;
   localparam int BIT_GEN1_SEL = 0;
   localparam logic [7:0] STATUS_W1U_MASK = 8'hfa;
   typedef enum logic [1:0] {VIEW_VACANCY = 2'b00, VIEW_INT = 2'b01,
                             VIEW_DMA = 2'b11} view_t;
endpackage

// [rtl/tx_fifo.sv]
// parameterised transmit character fifo
`timescale 1ns/1ps
`default_nettype none
module tx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic i_core_clk,           // core clock
   input wire logic i_rstn,               // sync reset, active low
   input wire logic i_in_valid,           // write side valid
   output logic o_in_ready,               // write side ready
   input wire logic [WIDTH-1:0] i_in_data, // write data
   output logic o_out_valid,              // read side valid
   input wire logic i_out_ready,          // read side ready
   output logic [WIDTH-1:0] o_out_data,   // read data
   output logic [AW:0] o_count            // entries held
);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   wire push = i_in_valid && o_in_ready;
   wire pop = o_out_valid && i_out_ready;
   assign o_in_ready = (count_r != (AW+1)'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data = mem_r[rd_ptr_r];
   assign o_count = count_r;
   always_ff @(posedge i_core_clk) begin
      if (push) mem_r[wr_ptr_r] <= i_in_data;
   end
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// [rtl/serial_tx_control_regs.sv]
// transmit-side register bank of one serial channel
// What this block does
// R1 - the data port decodes at 1x000 with bit 5 clear or at any address with bit 5 set.
// R2 - in the vacancy view the upper control byte reads the empty fifo entries and ignores writes.
// R3 - interrupt view: the upper byte is a threshold; data irq asks while vacancy exceeds it.
// R4 - dma view: the upper byte is a threshold; dma request asks while vacancy exceeds it.
// R5 - arm bits 7, 4 and 3 enable preamble, frame-end and crc sent interrupts in sync modes.
// R6 - arm bit 6 enables the idle-sent interrupt.
// R7 - arm bit 5 enables the abort-sent interrupt in hdlc/sdlc mode.
// R8 - arm bit 1 enables the underflow interrupt.
// R9 - with hold bit 2 set in sync mode each frame waits for a send-frame command.
// R10 - bit 0 selects time constant (0) or captured count (1) for generator 1 readback.
// R11 - the mode register decodes at 11001 with bit 5 clear.
// R12 - commands 0101, 0110, 0111 select vacancy, interrupt or dma view of the upper byte.
// R13 - command 1000 with hold set releases the next frame.
// R14 - latched status bits are readable and cleared by writing one.
// R15 - a status interrupt asks only while its latched bit and arm bit are both set.
// R16 - each accepted data write pushes one character, or two on a 16-bit write; a write while not ready pushes none.
`timescale 1ns/1ps
`default_nettype none
module serial_tx_control_regs
   import tx_regs_pkg::*;
(
   input wire logic i_core_clk,            // 50 MHz core clock
   input wire logic i_rstn,                // sync reset, active low
   input wire logic [ADDR_W-1:0] i_addr,   // register address
   input wire logic i_wr,                  // write strobe, one cycle
   input wire logic i_rd,                  // read strobe
   input wire logic i_wide,                // 16-bit access
   input wire logic [15:0] i_wdata,        // write data
   output logic [15:0] o_rdata,            // read data, registered
   output logic o_data_ready,              // data port can take a write
   input wire logic i_sync_mode,           // transmitter in a sync mode
   input wire logic i_hdlc_mode,           // transmitter in hdlc/sdlc
   input wire logic i_ev_preamble,         // preamble sent pulse
   input wire logic i_ev_idle,             // idle sent pulse
   input wire logic i_ev_abort,            // abort sent pulse
   input wire logic i_ev_frame_end,        // end of frame sent pulse
   input wire logic i_ev_crc,              // crc sent pulse
   input wire logic i_ev_underflow,        // underflow pulse
   input wire logic i_frame_start_req,     // transmitter wants to start a frame
   output logic o_frame_go,                // frame may start
   input wire logic i_char_ready,          // transmitter takes a character
   output logic o_char_valid,              // character available
   output logic [7:0] o_char_data,         // character
   input wire logic [15:0] i_gen1_const,   // generator 1 time constant
   input wire logic [15:0] i_gen1_count,   // generator 1 live count
   output logic [15:0] o_gen1_readback,    // generator 1 readback value
   output logic [15:0] o_tx_mode,          // mode register contents
   output logic o_data_irq,                // transmit data interrupt request
   output logic o_dma_req,                 // transmit dma request
   output logic o_status_irq               // transmit status interrupt request
);
   logic [15:0] mode_r;
   logic [7:0] ictrl_lo_r;
   logic [7:0] int_thresh_r;
   logic [7:0] dma_thresh_r;
   view_t view_r;
   logic [7:0] stat_r;
   logic [7:0] stat_nxt;
   logic hold_release_r;
   logic [15:0] gen1_cap_r;
   logic [15:0] rdata_r;
   logic [7:0] pend_r;
   logic pend_valid_r;
   logic [FIFO_AW:0] fifo_count;

   wire hi_sel = i_addr[5];
   wire [4:0] reg_a = i_addr[4:0];
   wire hit_data = hi_sel || ((reg_a & TX_DATA_MASK) == TX_DATA_ADDR); // [R1]
   wire hit_mode = !hi_sel && (reg_a == TX_MODE_ADDR);                 // [R11]
   wire hit_cmd = !hi_sel && (reg_a == TX_CMD_STAT_ADDR);
   wire hit_ictrl = !hi_sel && (reg_a == TX_INT_CTRL_ADDR);
   wire wr_data = i_wr && hit_data;
   wire wr_mode = i_wr && hit_mode;
   wire wr_cmd = i_wr && hit_cmd;
   wire wr_ictrl = i_wr && hit_ictrl;
   wire [3:0] cmd = i_wdata[CMD_LSB+3:CMD_LSB];
   wire hold_on = ictrl_lo_r[BIT_HOLD] && i_sync_mode;

   // vacancy; never negative since count stays within depth
   wire [7:0] vacancy = 8'(FIFO_DEPTH) - 8'(fifo_count);

   // a 16-bit write queues low byte first, high byte held one cycle
   // a refused write must not leave half a wide word in the queue
   wire data_take = wr_data && o_data_ready;
   wire fifo_in_valid = pend_valid_r || data_take;
   wire [7:0] fifo_in_data = pend_valid_r ? pend_r : i_wdata[7:0];
   wire fifo_in_ready;
   assign o_data_ready = fifo_in_ready && !pend_valid_r &&
                         (vacancy >= 8'h02 || !i_wide);

   tx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_in_valid(fifo_in_valid),
      .o_in_ready(fifo_in_ready),
      .i_in_data(fifo_in_data),
      .o_out_valid(o_char_valid),
      .i_out_ready(i_char_ready),
      .o_out_data(o_char_data),
      .o_count(fifo_count)
   );

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         pend_valid_r <= 1'b0;
         pend_r <= 8'h00;
      end else if (pend_valid_r) begin
         pend_valid_r <= 1'b0;
      end else if (data_take && i_wide) begin
         pend_valid_r <= 1'b1;                                        // [R16]
         pend_r <= i_wdata[15:8];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         mode_r <= TX_MODE_RESET;
      end else if (wr_mode) begin
         mode_r <= i_wdata;
      end
   end
   assign o_tx_mode = mode_r;

   wire [2:0] view_wr_sel = {view_r == VIEW_DMA, view_r == VIEW_INT, view_r == VIEW_VACANCY};
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         view_r <= VIEW_VACANCY;
         ictrl_lo_r <= TX_ICTRL_LO_RESET;
         int_thresh_r <= THRESH_RESET;
         dma_thresh_r <= THRESH_RESET;
      end else begin
         if (wr_cmd) begin
            unique case (cmd)                                         // [R12]
               CMD_VIEW_VACANCY: view_r <= VIEW_VACANCY;
               CMD_VIEW_INT: view_r <= VIEW_INT;
               CMD_VIEW_DMA: view_r <= VIEW_DMA;
               default: view_r <= view_r;
            endcase
         end
         if (wr_ictrl) begin
            ictrl_lo_r <= i_wdata[7:0];
            if (i_wide && view_wr_sel[1]) int_thresh_r <= i_wdata[15:8]; // [R3]
            if (i_wide && view_wr_sel[2]) dma_thresh_r <= i_wdata[15:8]; // [R4]
         end
      end
   end

   // send-frame command releases exactly one waiting frame
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         hold_release_r <= 1'b0;
      end else if (wr_cmd && cmd == CMD_SEND_FRAME && hold_on) begin
         hold_release_r <= 1'b1;                                      // [R13]
      end else if (i_frame_start_req && o_frame_go) begin
         hold_release_r <= 1'b0;
      end
   end
   assign o_frame_go = !hold_on || hold_release_r;                    // [R9]

   // latched status: a new event wins over a same-cycle write-one clear
   wire [7:0] ev = {i_ev_preamble, i_ev_idle, i_ev_abort, i_ev_frame_end,
                    i_ev_crc, 1'b0, i_ev_underflow, 1'b0};
   wire [7:0] clr = (wr_cmd ? i_wdata[7:0] : 8'h00) & STATUS_W1U_MASK;
   assign stat_nxt = (stat_r & ~clr) | ev;                            // [R14]
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) stat_r <= 8'h00;
      else stat_r <= stat_nxt;
   end

   // mode qualifiers gate each arm bit to the modes where it has meaning
   wire [7:0] mode_ok = {i_sync_mode, 1'b1, i_hdlc_mode, i_sync_mode, i_sync_mode,
                         1'b0, 1'b1, 1'b0};
   wire [7:0] armed = ictrl_lo_r & mode_ok;                           // [R5] [R6] [R7] [R8]
   assign o_status_irq = |(stat_r & armed);                           // [R15]
   assign o_data_irq = (vacancy > int_thresh_r);                      // [R3]
   assign o_dma_req = (vacancy > dma_thresh_r);                       // [R4]

   // count capture happens when the select bit is written to one
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) gen1_cap_r <= 16'h0000;
      else if (wr_ictrl && i_wdata[BIT_GEN1_SEL]) gen1_cap_r <= i_gen1_count;
   end
   assign o_gen1_readback = ictrl_lo_r[BIT_GEN1_SEL] ? gen1_cap_r : i_gen1_const; // [R10]

   wire [7:0] ictrl_hi = (view_r == VIEW_VACANCY) ? vacancy :        // [R2]
                         (view_r == VIEW_INT) ? int_thresh_r : dma_thresh_r;
   wire [15:0] cmd_rd = {4'h0, 4'h0, stat_r[7:1], fifo_count == '0};
   wire [15:0] rd_mux = hit_mode ? mode_r :
                        hit_cmd ? cmd_rd :
                        hit_ictrl ? {ictrl_hi, ictrl_lo_r} : 16'h0000;
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) rdata_r <= 16'h0000;
      else if (i_rd) rdata_r <= rd_mux;
   end
   assign o_rdata = rdata_r;

   a_status_irq_cause: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R15]
      o_status_irq |-> |(stat_r & ictrl_lo_r))
      else $error("status irq without armed latched bit");
   a_underflow_latch: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R14]
      i_ev_underflow |=> stat_r[BIT_UNDERFLOW])
      else $error("underflow event lost");
   a_w1u_clear: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R14]
      (wr_cmd && i_wdata[BIT_CRC] && !i_ev_crc) |=> !stat_r[BIT_CRC])
      else $error("crc status not cleared");
   a_hold_blocks: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R9]
      (hold_on && !hold_release_r) |-> !o_frame_go)
      else $error("frame released without command");
   a_send_release: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R13]
      (wr_cmd && cmd == CMD_SEND_FRAME && hold_on) |=> o_frame_go)
      else $error("send frame did not release");
   a_wide_push: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R16]
      (wr_data && i_wide && !pend_valid_r && o_data_ready) |=> ##1
      (fifo_count == $past(fifo_count, 2) + 2) || $past(i_char_ready) || $past(i_char_ready, 2))
      else $error("wide write did not push two characters");
   a_view_select: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R12]
      (wr_cmd && cmd == CMD_VIEW_INT) |=> view_r == VIEW_INT)
      else $error("interrupt view not selected");
   a_data_irq_level: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R3]
      (vacancy <= int_thresh_r) |-> !o_data_irq)
      else $error("data irq at or below threshold");
   a_vacancy_ro: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R2]
      (wr_ictrl && view_r == VIEW_VACANCY) |=>
      (int_thresh_r == $past(int_thresh_r)) && (dma_thresh_r == $past(dma_thresh_r)))
      else $error("vacancy view write changed a threshold");

   // gating and side effects seen from the outputs and internal registers
   a_dma_req_level: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R4]
      (vacancy <= dma_thresh_r) |-> !o_dma_req)
      else $error("dma request at or below threshold");
   a_data_decode: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R1]
      (i_wr && i_addr[5] && o_data_ready) |=> (fifo_count != $past(fifo_count)) || $past(i_char_ready))
      else $error("high select write did not reach the data port");
   a_mode_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R11]
      wr_mode |=> o_tx_mode == $past(i_wdata))
      else $error("mode register write lost");
   a_narrow_push: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R16]
      (wr_data && !i_wide && o_data_ready && !i_char_ready) |=> fifo_count == $past(fifo_count) + 1)
      else $error("narrow write did not push one character");
   a_gen1_capture: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R10]
      (wr_ictrl && i_wdata[BIT_GEN1_SEL]) |=> o_gen1_readback == $past(i_gen1_count))
      else $error("generator count not captured");
   a_abort_gate: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R7]
      (!i_hdlc_mode && (stat_r & 8'hdf) == 8'h00) |-> !o_status_irq)
      else $error("abort interrupt outside hdlc mode");
   a_sync_gate: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R5]
      (!i_sync_mode && !i_hdlc_mode && (stat_r & 8'h42) == 8'h00) |-> !o_status_irq)
      else $error("sync-only interrupt outside sync mode");
   a_underflow_irq: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R8]
      (stat_r[BIT_UNDERFLOW] && ictrl_lo_r[BIT_UNDERFLOW]) |-> o_status_irq)
      else $error("armed underflow gave no interrupt");
   a_idle_irq: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R6]
      (stat_r[BIT_IDLE] && ictrl_lo_r[BIT_IDLE]) |-> o_status_irq)
      else $error("armed idle sent gave no interrupt");
   a_release_clear: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R13]
      (i_frame_start_req && o_frame_go && !(wr_cmd && cmd == CMD_SEND_FRAME && hold_on))
      |=> !hold_release_r)
      else $error("release kept after frame start");
   a_vacancy_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R2]
      (i_rd && hit_ictrl && view_r == VIEW_VACANCY) |=> o_rdata[15:8] == $past(vacancy))
      else $error("vacancy read wrong");
   a_thresh_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R3]
      (wr_ictrl && i_wide && view_r == VIEW_INT) |=> int_thresh_r == $past(i_wdata[15:8]))
      else $error("interrupt threshold not written");
   a_dma_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [R4]
      (wr_ictrl && i_wide && view_r == VIEW_DMA) |=> dma_thresh_r == $past(i_wdata[15:8]))
      else $error("dma threshold not written");
endmodule
`default_nettype wire

// [tb/tx_line_model.sv]
// behavioural transmitter that drains characters and starts frames
`timescale 1ns/1ps
`default_nettype none
module tx_line_model (
   input wire logic i_core_clk,        // core clock
   input wire logic i_rstn,            // sync reset, active low
   input wire logic i_stall,           // slow answer: hold off character reads
   input wire logic i_want_frame,      // bench asks for a frame start
   input wire logic i_frame_go,        // frame may start
   output logic o_frame_start_req,     // start request level
   input wire logic i_char_valid,      // character available
   input wire logic [7:0] i_char_data, // character
   output logic o_char_ready,          // character taken
   output logic [7:0] o_last_char,     // last character taken
   output logic [7:0] o_char_count,    // characters taken
   output logic [7:0] o_frame_count    // frames started
);
   logic pending_r;
   assign o_char_ready = !i_stall;
   assign o_frame_start_req = pending_r;
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         pending_r <= 1'b0;
         o_last_char <= 8'h00;
         o_char_count <= 8'h00;
         o_frame_count <= 8'h00;
      end else begin
         if (i_char_valid && o_char_ready) begin
            o_last_char <= i_char_data;
            o_char_count <= o_char_count + 8'h01;
         end
         // a frame only starts once the hold is lifted
         if (pending_r && i_frame_go) begin
            pending_r <= 1'b0;
            o_frame_count <= o_frame_count + 8'h01;
         end else if (i_want_frame) begin
            pending_r <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the transmit register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tx_regs_pkg::*;
   logic clk, rstn, wr, rd, wide, sync, hdlc, stall, want, go, req, cv, cr;
   logic [5:0] addr;
   logic [15:0] wdata, rdata, gconst, gcount, gread, tmode;
   logic [7:0] ev, cdata, last_c, n_c, n_f;
   logic dready, dirq, dreq, sirq;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int k;
   serial_tx_control_regs dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wr(wr),
      .i_rd(rd), .i_wide(wide), .i_wdata(wdata), .o_rdata(rdata), .o_data_ready(dready),
      .i_sync_mode(sync), .i_hdlc_mode(hdlc), .i_ev_preamble(ev[7]), .i_ev_idle(ev[6]),
      .i_ev_abort(ev[5]), .i_ev_frame_end(ev[4]), .i_ev_crc(ev[3]), .i_ev_underflow(ev[1]),
      .i_frame_start_req(req), .o_frame_go(go), .i_char_ready(cr), .o_char_valid(cv),
      .o_char_data(cdata), .i_gen1_const(gconst), .i_gen1_count(gcount),
      .o_gen1_readback(gread), .o_tx_mode(tmode), .o_data_irq(dirq), .o_dma_req(dreq),
      .o_status_irq(sirq));
   tx_line_model model_u (.i_core_clk(clk), .i_rstn(rstn), .i_stall(stall), .i_want_frame(want),
      .i_frame_go(go), .o_frame_start_req(req), .i_char_valid(cv), .i_char_data(cdata),
      .o_char_ready(cr), .o_last_char(last_c), .o_char_count(n_c), .o_frame_count(n_f));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         final_report();
      end
   end
   task automatic final_report();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one write strobe; callers start at a falling edge
   task automatic wrr(input logic [5:0] a, input logic [15:0] d, input logic w);
      addr = a;
      wdata = d;
      wide = w;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic rdr(input logic [5:0] a, input logic [15:0] exp);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      chk16(rdata, exp);
   endtask
   task automatic pulse(input int b);
      ev[b] = 1'b1;
      @(negedge clk);
      ev = 8'h00;
      @(negedge clk);
   endtask
   initial begin
      {rstn, wr, rd, wide, sync, hdlc, want} = '0;
      addr = 6'h00;
      wdata = 16'h0000;
      ev = 8'h00;
      stall = 1'b1;
      gconst = 16'h1234;
      gcount = 16'h5678;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      chk1(dirq, 1'b1);
      chk1(dreq, 1'b1);
      rdr(6'h1b, 16'h2000);
      wrr(6'h19, 16'ha5c3, 1'b1);
      rdr(6'h19, 16'ha5c3);
      wrr(6'h10, 16'h4241, 1'b1);
      wrr(6'h18, 16'h0043, 1'b0);
      wrr(6'h39, 16'h0044, 1'b0);
      rdr(6'h1b, 16'h1c00);
      chk16(tmode, 16'ha5c3);
      wrr(6'h1b, 16'hff00, 1'b1);
      rdr(6'h1b, 16'h1c00);
      wrr(6'h1a, 16'h6000, 1'b1);
      wrr(6'h1b, 16'h1b00, 1'b1);
      chk1(dirq, 1'b1);
      wrr(6'h1b, 16'h1c00, 1'b1);
      chk1(dirq, 1'b0);
      rdr(6'h1b, 16'h1c00);
      wrr(6'h1a, 16'h7000, 1'b1);
      wrr(6'h1b, 16'h1c00, 1'b1);
      chk1(dreq, 1'b0);
      wrr(6'h1b, 16'h1b00, 1'b1);
      chk1(dreq, 1'b1);
      chk1(dirq, 1'b0);
      wrr(6'h1a, 16'h5000, 1'b1);
      rdr(6'h1b, 16'h1c00);
      for (k = 0; k < 28; k++) wrr(6'h10, 16'(k), 1'b0);
      chk1(dready, 1'b0);
      wrr(6'h10, 16'h00ee, 1'b0);
      rdr(6'h1b, 16'h0000);
      stall = 1'b0;
      for (k = 0; k < 200 && n_c != 8'd32; k++) @(negedge clk);
      chk16({8'h00, n_c}, 16'h0020);
      chk16({8'h00, last_c}, 16'h001b);
      rdr(6'h1b, 16'h2000);
      sync = 1'b1;
      hdlc = 1'b1;
      for (k = 1; k < 8; k++) begin
         if (k == 2) continue;
         pulse(k);
         chk1(sirq, 1'b0);
         rdr(6'h1a, 16'(1 << k) | 16'h0001);
         wrr(6'h1b, 16'(1 << k), 1'b0);
         chk1(sirq, 1'b1);
         wrr(6'h1a, 16'(1 << k), 1'b0);
         chk1(sirq, 1'b0);
         wrr(6'h1b, 16'h0000, 1'b0);
      end
      hdlc = 1'b0;
      pulse(5);
      wrr(6'h1b, 16'h0020, 1'b0);
      chk1(sirq, 1'b0);
      wrr(6'h1a, 16'h0020, 1'b0);
      wrr(6'h1b, 16'h0004, 1'b0);
      chk1(go, 1'b0);
      want = 1'b1;
      @(negedge clk);
      want = 1'b0;
      repeat (5) @(negedge clk);
      chk16({8'h00, n_f}, 16'h0000);
      wrr(6'h1a, 16'h8000, 1'b1);
      for (k = 0; k < 10 && n_f == 8'h00; k++) @(negedge clk);
      chk16({8'h00, n_f}, 16'h0001);
      chk1(go, 1'b0);
      chk16(gread, 16'h1234);
      wrr(6'h1b, 16'h0001, 1'b0);
      gcount = 16'h9999;
      @(negedge clk);
      chk16(gread, 16'h5678);
      final_report();
   end
endmodule
`default_nettype wire
